// ===== src/opcode_pkg.sv
// constants for the advanced/test opcode interpreter.
// assumes a 32-bit axi4-lite master and a converter array with a scan interface outside.
// Behaviour
// (R1) error opcode returns one word, low eleven bits are converter error flags.
// (R2) lock opcode returns one word, bit 0 shows the converter loop lock.
// (R3) status opcode returns 62-bit status as four words; host reads all four.
// (R4) single load opcode loads held scan image into converter n only.
// (R5) after an opcode, wait until every parameter or result word is moved.
// (R6) eeprom write takes address word then datum word; low byte is stored.
// (R7) host should avoid eeprom writes to reserved region 0x0 to 0x28.
// (R8) eeprom layout: flag 0x02, version 0x03, fw 0x04-0x07, autoload 0x08, user 0x18-0x28.
// (R9) old firmware needs host delay over 10 ms after each eeprom write.
// (R10) eeprom read takes address word, then returns byte in bits 7..0.
// (R11) identity opcode returns revision, day, month, year words in that order.
// (R12) loopback variable written and read by own opcodes, resets to 0x5555.
// (R13) test mode with trigger matching replaces event data with test words.
// (R14) test enable takes low sixteen pattern bits then high eight bits.
// (R15) test word carries 001000 in bits 31..26 above the pattern.
// (R16) test disable opcode turns test mode off.
// (R17) test output select uses bits 3..0 only, default 1110.
// (R18) clock source select uses bits 1..0, four sources.
// (R19) scan readout returns 41 words covering 656 scan bits with parity; host reads all.
// (R20) converter index sits in the low opcode digit, range set by variant.
// (R21) all-converter load opcode loads held scan image into every converter.
// (R22) readable handshake flags show when the data port may be written or read.
package opcode_pkg;
  localparam logic [7:0]  A_CMD       = 8'h00; // command data port
  localparam logic [7:0]  A_HSK       = 8'h04; // handshake flags
  localparam logic [7:0]  A_CTRL      = 8'h08; // trigger matching enable
  localparam logic [7:0]  A_STAT      = 8'h0c; // words still to move
  localparam int          HSK_WOK     = 0;
  localparam int          HSK_ROK     = 1;
  localparam logic [15:0] SPARE_RST   = 16'h5555;
  localparam logic [3:0]  TOUT_RST    = 4'he;
  localparam logic [1:0]  CLKSRC_RST  = 2'h3;
  localparam logic [5:0]  TEST_TAG    = 6'h08;
  localparam int          SCAN_WORDS  = 41;
  localparam int          STAT_WORDS  = 4;
  localparam int          ID_WORDS    = 4;
  localparam int          ERR_BITS    = 11;
  localparam int          EE_BYTES    = 512;
  localparam logic [7:0]  OP_LOAD_ALL = 8'h72;
  localparam logic [7:0]  OP_ERR      = 8'h74;
  localparam logic [7:0]  OP_LOCK     = 8'h75;
  localparam logic [7:0]  OP_STAT     = 8'h76;
  localparam logic [7:0]  OP_LOAD_ONE = 8'h77;
  localparam logic [7:0]  OP_EE_WR    = 8'hc0;
  localparam logic [7:0]  OP_EE_RD    = 8'hc1;
  localparam logic [7:0]  OP_IDENT    = 8'hc2;
  localparam logic [7:0]  OP_SPARE_WR = 8'hc3;
  localparam logic [7:0]  OP_SPARE_RD = 8'hc4;
  localparam logic [7:0]  OP_TEST_EN  = 8'hc5;
  localparam logic [7:0]  OP_TEST_DIS = 8'hc6;
  localparam logic [7:0]  OP_TOUT     = 8'hc7;
  localparam logic [7:0]  OP_CLKSRC   = 8'hc8;
  localparam logic [7:0]  OP_SCAN_RD  = 8'hc9;
  localparam logic [15:0] EE_A_FLAG   = 16'h0002; // R8
  localparam logic [15:0] EE_A_VER    = 16'h0003;
  localparam logic [15:0] EE_A_FWREV  = 16'h0004;
  localparam logic [15:0] EE_A_AUTO   = 16'h0008;
  localparam logic [15:0] EE_A_USER0  = 16'h0018;
  localparam logic [15:0] EE_A_USER1  = 16'h0028;
  typedef enum logic [2:0] {ST_IDLE, ST_WRPAR, ST_RDRES, ST_LOAD} state_type;
endpackage

// ===== src/tdc_opcode_interp.sv
// advanced/test opcode interpreter with axi4-lite register access.
// assumes converter status, lock, error and scan-image sources on plain ports.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tdc_opcode_interp #(
  parameter int N_TDC = 4,
  parameter logic [15:0] FW_REV   = 16'h0010, // arbitrary
  parameter logic [15:0] FW_DAY   = 16'h0001, // arbitrary
  parameter logic [15:0] FW_MONTH = 16'h0001, // arbitrary
  parameter logic [15:0] FW_YEAR  = 16'h0001  // arbitrary
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic [7:0]            s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [7:0]            s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  input  wire logic [N_TDC*11-1:0]   tdc_err_i,
  input  wire logic [N_TDC-1:0]      tdc_lock_i,
  input  wire logic [N_TDC*62-1:0]   tdc_status_i,
  input  wire logic [N_TDC*656-1:0]  tdc_scan_i,
  input  wire logic                  trig_i,
  input  wire logic                  tdc_load_done_i,
  output logic [N_TDC-1:0]           tdc_load_o,
  output logic                       ee_we_o,
  output logic [8:0]                 ee_addr_o,
  output logic [7:0]                 ee_wdata_o,
  input  wire logic [7:0]            ee_rdata_i,
  output logic                       test_mode_o,
  output logic [31:0]                test_word_o,
  output logic                       test_insert_o,
  output logic [3:0]                 test_out_sel_o,
  output logic [1:0]                 dll_clk_src_o
);
  import opcode_pkg::*;

  state_type   state_r;
  logic [7:0]  op_r;
  logic [1:0]  tdc_r;
  logic [5:0]  cnt_r;      // words still to move
  logic [5:0]  idx_r;      // words already moved
  logic [15:0] par0_r;
  logic [15:0] rdw_r;      // result word on offer
  logic        rd_ok_r;
  logic [15:0] spare_r;
  logic [23:0] pattern_r;
  logic        tm_en_r;    // trigger matching active
  logic [N_TDC*11-1:0]  err_s1_r, err_s2_r;
  logic [N_TDC-1:0]     lock_s1_r, lock_s2_r;
  logic [N_TDC*62-1:0]  st_s1_r, st_s2_r;
  logic [1:0]           trig_sync_r;
  logic        aw_h_r, w_h_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic        wr_go, rd_go, cmd_wr, cmd_rd;
  logic [15:0] res_word;
  logic [61:0] cur_stat;
  logic [655:0] cur_scan;

  // two-stage capture of converter error, lock, status and trigger levels; scan image and load done are used directly
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      err_s1_r    <= '0;
      err_s2_r    <= '0;
      lock_s1_r   <= '0;
      lock_s2_r   <= '0;
      st_s1_r     <= '0;
      st_s2_r     <= '0;
      trig_sync_r <= '0;
    end else if (ce_i) begin
      err_s1_r    <= tdc_err_i;
      err_s2_r    <= err_s1_r;
      lock_s1_r   <= tdc_lock_i;
      lock_s2_r   <= lock_s1_r;
      st_s1_r     <= tdc_status_i;
      st_s2_r     <= st_s1_r;
      trig_sync_r <= {trig_sync_r[0], trig_i};
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
      awa_r  <= '0;
      wd_r   <= '0;
      s_axi_bvalid_o <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_h_r <= 1'b1;
        awa_r  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_h_r <= 1'b1;
        wd_r  <= s_axi_wdata_i;
      end
      if (wr_go) begin
        aw_h_r <= 1'b0;
        w_h_r  <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end
  assign wr_go  = aw_h_r && w_h_r && !s_axi_bvalid_o;
  // a port write while no word is wanted is dropped, still answered okay
  assign cmd_wr = wr_go && (awa_r == A_CMD) && (state_r == ST_IDLE || state_r == ST_WRPAR);

  // ready outputs come from flip-flops: open while nothing is held
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else if (ce_i) begin
      s_axi_awready_o <= !aw_h_r && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o  <= !w_h_r && !(s_axi_wvalid_i && s_axi_wready_o);
    end
  end

  // read channel, one cycle after address acceptance
  assign rd_go  = s_axi_arvalid_i && s_axi_arready_o;
  assign cmd_rd = rd_go && (s_axi_araddr_i == A_CMD) && rd_ok_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
    end else if (ce_i) begin
      s_axi_arready_o <= !s_axi_rvalid_o && !rd_go;
      if (rd_go) begin
        s_axi_rvalid_o <= 1'b1;
        case (s_axi_araddr_i)
          A_CMD:   s_axi_rdata_o <= {16'h0000, rd_ok_r ? rdw_r : 16'h0000};
          A_HSK:   s_axi_rdata_o <= {30'h0, rd_ok_r, state_r == ST_IDLE || state_r == ST_WRPAR}; // R22
          A_CTRL:  s_axi_rdata_o <= {31'h0, tm_en_r};
          A_STAT:  s_axi_rdata_o <= {26'h0, cnt_r};
          default: s_axi_rdata_o <= '0;
        endcase
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
  assign s_axi_bresp_o = 2'b00;
  assign s_axi_rresp_o = 2'b00;

  // control register: trigger matching enable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) tm_en_r <= 1'b0;
    else if (ce_i && wr_go && awa_r == A_CTRL && s_axi_wstrb_i[0] | 1'b1) tm_en_r <= wd_r[0];
  end

  // result word selection for the word about to be offered
  assign cur_stat = st_s2_r[tdc_r*62 +: 62];
  assign cur_scan = tdc_scan_i[tdc_r*656 +: 656];
  always_comb begin
    res_word = 16'h0000;
    case (op_r)
      OP_ERR:      res_word = {5'h00, err_s2_r[tdc_r*ERR_BITS +: ERR_BITS]}; // R1
      OP_LOCK:     res_word = {15'h0000, lock_s2_r[tdc_r]};                  // R2
      OP_STAT:     res_word = 16'({2'b00, cur_stat} >> {idx_r[1:0], 4'h0});     // R3
      OP_EE_RD:    res_word = {8'h00, ee_rdata_i};                           // R10
      OP_IDENT: begin                                                        // R11
        case (idx_r[1:0])
          2'd0:    res_word = FW_REV;
          2'd1:    res_word = FW_DAY;
          2'd2:    res_word = FW_MONTH;
          default: res_word = FW_YEAR;
        endcase
      end
      OP_SPARE_RD: res_word = spare_r;                                       // R12
      OP_SCAN_RD:  res_word = 16'(cur_scan >> (idx_r * 16));                 // R19
      default:     res_word = 16'h0000;
    endcase
  end

  // interpreter sequencer: stalls until every word is moved
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      op_r    <= '0;
      tdc_r   <= '0;
      cnt_r   <= '0;
      idx_r   <= '0;
      rd_ok_r <= 1'b0;
      rdw_r   <= '0;
    end else if (ce_i) begin
      case (state_r)
        ST_IDLE: if (cmd_wr) begin
          op_r  <= wd_r[15:8];
          tdc_r <= (wd_r[3:0] < 4'(N_TDC)) ? wd_r[1:0] : 2'd0;                  // R20
          idx_r <= '0;
          case (wd_r[15:8])
            OP_ERR, OP_LOCK, OP_SPARE_RD: begin cnt_r <= 6'd1; state_r <= ST_RDRES; end
            OP_STAT:    begin cnt_r <= 6'(STAT_WORDS); state_r <= ST_RDRES; end // R3
            OP_IDENT:   begin cnt_r <= 6'(ID_WORDS); state_r <= ST_RDRES; end
            OP_SCAN_RD: begin cnt_r <= 6'(SCAN_WORDS); state_r <= ST_RDRES; end // R19
            OP_EE_WR, OP_TEST_EN: begin cnt_r <= 6'd2; state_r <= ST_WRPAR; end // R5
            OP_EE_RD, OP_SPARE_WR, OP_TOUT, OP_CLKSRC: begin
              cnt_r <= 6'd1; state_r <= ST_WRPAR;
            end
            OP_LOAD_ALL, OP_LOAD_ONE: state_r <= ST_LOAD;
            default: state_r <= ST_IDLE;
          endcase
        end
        ST_WRPAR: if (cmd_wr) begin                                            // R5
          idx_r <= idx_r + 6'd1;
          cnt_r <= cnt_r - 6'd1;
          if (cnt_r == 6'd1) begin
            if (op_r == OP_EE_RD) begin
              cnt_r   <= 6'd1;
              idx_r   <= '0;
              state_r <= ST_RDRES;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RDRES: begin
          if (!rd_ok_r) begin
            rdw_r   <= res_word;
            rd_ok_r <= 1'b1;
          end else if (cmd_rd) begin                                           // R5
            rd_ok_r <= 1'b0;
            idx_r   <= idx_r + 6'd1;
            cnt_r   <= cnt_r - 6'd1;
            if (cnt_r == 6'd1) state_r <= ST_IDLE;
          end
        end
        ST_LOAD: if (tdc_load_done_i) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // scan-image load strobes held until the converter array finishes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) tdc_load_o <= '0;
    else if (ce_i) begin
      if (state_r == ST_LOAD && tdc_load_done_i) tdc_load_o <= '0;
      else if (state_r == ST_LOAD && op_r == OP_LOAD_ALL) tdc_load_o <= '1;        // R21
      else if (state_r == ST_LOAD) tdc_load_o <= N_TDC'(1) << tdc_r;             // R4
    end
  end

  // parameter words steer settings and eeprom
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      par0_r         <= '0;
      spare_r        <= SPARE_RST;                                          // R12
      pattern_r      <= '0;
      test_mode_o    <= 1'b0;
      test_out_sel_o <= TOUT_RST;
      dll_clk_src_o  <= CLKSRC_RST;
      ee_we_o        <= 1'b0;
      ee_addr_o      <= '0;
      ee_wdata_o     <= '0;
    end else if (ce_i) begin
      ee_we_o <= 1'b0;
      if (state_r == ST_IDLE && cmd_wr && wd_r[15:8] == OP_TEST_DIS)
        test_mode_o <= 1'b0;                                                // R16
      if (state_r == ST_WRPAR && cmd_wr) begin
        if (idx_r == 6'd0) par0_r <= wd_r[15:0];
        case (op_r)
          OP_EE_WR: if (idx_r == 6'd1) begin                                // R6
            ee_addr_o  <= par0_r[8:0];
            ee_wdata_o <= wd_r[7:0];
            ee_we_o    <= 1'b1;
          end
          OP_EE_RD:    ee_addr_o <= wd_r[8:0];                              // R10
          OP_SPARE_WR: spare_r <= wd_r[15:0];                               // R12
          OP_TEST_EN: begin                                                 // R14
            if (idx_r == 6'd0) pattern_r[15:0] <= wd_r[15:0];
            else begin
              pattern_r[23:16] <= wd_r[7:0];
              test_mode_o      <= 1'b1;
            end
          end
          OP_TOUT:   test_out_sel_o <= wd_r[3:0];                           // R17
          OP_CLKSRC: dll_clk_src_o  <= wd_r[1:0];                           // R18
          default: ;
        endcase
      end
    end
  end

  // test word and its insertion strobe per trigger
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      test_word_o   <= '0;
      test_insert_o <= 1'b0;
    end else if (ce_i) begin
      test_word_o   <= {TEST_TAG, 2'b00, pattern_r};                        // R15
      test_insert_o <= test_mode_o && tm_en_r && trig_sync_r[1];            // R13
    end
  end

  // steps of a transfer, shared by the checks below
  sequence s_stat_op;
    ce_i && cmd_wr && state_r == ST_IDLE && wd_r[15:8] == OP_STAT;
  endsequence
  sequence s_scan_op;
    ce_i && cmd_wr && state_r == ST_IDLE && wd_r[15:8] == OP_SCAN_RD;
  endsequence
  sequence s_pat_lo;
    ce_i && cmd_wr && state_r == ST_WRPAR && op_r == OP_TEST_EN && idx_r == 6'd0;
  endsequence
  sequence s_pat_hi;
    ce_i && cmd_wr && state_r == ST_WRPAR && op_r == OP_TEST_EN && idx_r == 6'd1;
  endsequence

  a_load_one: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R4
    (state_r == ST_LOAD && op_r == OP_LOAD_ONE && !tdc_load_done_i && ce_i)
      |=> tdc_load_o == N_TDC'(1) << $past(tdc_r))
    else $error("single load touches other converters");
  a_spare_reset: assert property (@(posedge sys_clk_i) // R12
    $rose(!rst_i) |-> spare_r == SPARE_RST)
    else $error("loopback reset value wrong");
  a_test_tag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R15
    test_insert_o |-> test_word_o[31:26] == 6'h08)
    else $error("test word tag wrong");
  a_test_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R16
    (ce_i && cmd_wr && state_r == ST_IDLE && wd_r[15:8] == OP_TEST_DIS) |=> !test_mode_o)
    else $error("test mode stays on");
  a_stall_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R5
    (state_r == ST_RDRES && !cmd_rd && rd_ok_r) |=> state_r == ST_RDRES)
    else $error("interpreter left wait early");
  a_eeprom_wr: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R6
    (ce_i && cmd_wr && state_r == ST_WRPAR && op_r == OP_EE_WR && idx_r == 6'd1)
      |=> ee_we_o && ee_wdata_o == $past(wd_r[7:0]))
    else $error("eeprom byte not stored");
  a_clk_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R18
    (ce_i && cmd_wr && state_r == ST_WRPAR && op_r == OP_CLKSRC)
      |=> dll_clk_src_o == $past(wd_r[1:0]))
    else $error("clock source not taken");
  a_tout_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R17
    (ce_i && cmd_wr && state_r == ST_WRPAR && op_r == OP_TOUT)
      |=> test_out_sel_o == $past(wd_r[3:0]))
    else $error("test output select not taken");
  a_stat_words: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R3
    s_stat_op |=> state_r == ST_RDRES && cnt_r == 6'd4)
    else $error("status word count wrong");
  a_scan_words: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R19
    s_scan_op |=> state_r == ST_RDRES && cnt_r == 6'd41)
    else $error("scan word count wrong");
  a_pat_low: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R14
    s_pat_lo |=> pattern_r[15:0] == $past(wd_r[15:0]))
    else $error("pattern low word lost");
  a_pat_high: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R14
    s_pat_hi |=> test_mode_o && pattern_r[23:16] == $past(wd_r[7:0]))
    else $error("pattern high byte lost");
  a_load_all: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R21
    (ce_i && state_r == ST_LOAD && op_r == OP_LOAD_ALL && !tdc_load_done_i)
      |=> tdc_load_o == '1)
    else $error("full load misses converters");
endmodule
`default_nettype wire

// ===== tb/tdc_far_model.sv
// stand-in for the converter array and the byte eeprom behind the interpreter.
// assumes the interpreter's clock; converter data are fixed, known patterns.
`timescale 1ns/1ns
`default_nettype none
module tdc_far_model #(
  parameter int N_TDC = 4
) (
  input  wire logic                 sys_clk_i,
  input  wire logic [N_TDC-1:0]     load_i,
  output logic                      load_done_o,
  output logic [N_TDC*11-1:0]       err_o,
  output logic [N_TDC-1:0]          lock_o,
  output logic [N_TDC*62-1:0]       status_o,
  output logic [N_TDC*656-1:0]      scan_o,
  input  wire logic                 ee_we_i,
  input  wire logic [8:0]           ee_addr_i,
  input  wire logic [7:0]           ee_wdata_i,
  output logic [7:0]                ee_rdata_o
);
  logic [7:0] mem [512];
  logic [2:0] cnt = 3'h0;

  // per-converter error, status and scan patterns differ so a wrong index shows; lock bits only alternate
  assign lock_o = N_TDC'('ha);
  for (genvar i = 0; i < N_TDC; i++) begin : g_tdc
    assign err_o[i*11 +: 11]    = 11'h5a5 ^ 11'(i);
    assign status_o[i*62 +: 62] = {14'h2a50 + 14'(i), 48'h0123_4567_89ab};
    for (genvar k = 0; k < 41; k++) begin : g_word
      assign scan_o[i*656+k*16 +: 16] = 16'(i*4096 + k*7 + 1);
    end
  end

  // byte memory, written on the strobe, read straight from the address
  initial for (int a = 0; a < 512; a++) mem[a] = 8'h00;
  always @(posedge sys_clk_i) if (ee_we_i) mem[ee_addr_i] <= ee_wdata_i;
  assign ee_rdata_o = mem[ee_addr_i];

  // a load takes a few cycles, so the interpreter must really wait for it
  initial load_done_o = 1'b0;
  always @(posedge sys_clk_i) begin
    load_done_o <= 1'b0;
    if (|load_i && !load_done_o) begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h4) begin
        load_done_o <= 1'b1;
        cnt <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the opcode interpreter, driven over axi4-lite.
// assumes the far-side model for converters and eeprom; one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import opcode_pkg::*;
  logic        sys_clk_i = 0, rst_i = 1, trig_i = 0;
  logic [7:0]  awaddr = 0, araddr = 0, ee_wdata, ee_rdata, wr_data;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, ld_done, ee_we, t_mode, t_ins;
  logic [31:0] wdata = 0, rdata, t_word;
  logic [1:0]  bresp, rresp, clk_src;
  logic [3:0]  tdc_load, out_sel;
  logic [43:0] err;
  logic [3:0]  lock;
  logic [247:0] status;
  logic [2623:0] scan;
  logic [8:0]  ee_addr, wr_addr;
  int          errors = 0, n_tests = 0, cycles = 0;
  // firmware identity words, values arbitrary
  localparam logic [15:0] ID [4] = '{16'h0021, 16'h0017, 16'h0005, 16'h07e7};

  tdc_opcode_interp #(.N_TDC(4), .FW_REV(ID[0]), .FW_DAY(ID[1]), .FW_MONTH(ID[2]),
    .FW_YEAR(ID[3])) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .tdc_err_i(err), .tdc_lock_i(lock),
    .tdc_status_i(status), .tdc_scan_i(scan), .trig_i(trig_i), .tdc_load_done_i(ld_done),
    .tdc_load_o(tdc_load), .ee_we_o(ee_we), .ee_addr_o(ee_addr), .ee_wdata_o(ee_wdata),
    .ee_rdata_i(ee_rdata), .test_mode_o(t_mode), .test_word_o(t_word),
    .test_insert_o(t_ins), .test_out_sel_o(out_sel), .dll_clk_src_o(clk_src));

  tdc_far_model #(.N_TDC(4)) far (.sys_clk_i(sys_clk_i), .load_i(tdc_load),
    .load_done_o(ld_done), .err_o(err), .lock_o(lock), .status_o(status), .scan_o(scan),
    .ee_we_i(ee_we), .ee_addr_i(ee_addr), .ee_wdata_i(ee_wdata), .ee_rdata_o(ee_rdata));

  initial forever #5 sys_clk_i = ~sys_clk_i;

  // remember what the last eeprom strobe carried
  always @(posedge sys_clk_i) if (ee_we === 1'b1) {wr_addr, wr_data} <= {ee_addr, ee_wdata};

  // hang guard, well above the roughly 1300 cycles the run needs
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // write with address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    forever begin
      @(posedge sys_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk("bresp", bresp, 0);
        break;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    {araddr, arvalid, rready} <= {a, 2'b11};
    forever begin
      @(posedge sys_clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        chk("rresp", rresp, 0);
        break;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic poll(input int b);
    logic [31:0] h = 0;
    while (h[b] !== 1'b1) axi_rd(A_HSK, h);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [3:0] n);
    poll(HSK_WOK);
    axi_wr(A_CMD, {16'h0, op, 4'h0, n});
  endtask

  task automatic put(input logic [15:0] w);
    poll(HSK_WOK);
    axi_wr(A_CMD, {16'h0, w});
  endtask

  task automatic get(output logic [15:0] w);
    logic [31:0] d;
    poll(HSK_ROK);
    axi_rd(A_CMD, d);
    w = d[15:0];
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [15:0] w;
    chk("out_sel", out_sel, TOUT_RST);
    chk("test_mode", t_mode, 0);
    axi_rd(A_CMD, d);
    chk("idle cmd read", d, 0);
    axi_rd(8'h40, d);
    chk("unmapped", d, 0);
    cmd(OP_SPARE_RD, 0);
    get(w);
    chk("spare reset", w, 16'h5555);
    cmd(OP_SPARE_WR, 0);
    put(16'ha3c5);
    cmd(OP_SPARE_RD, 0);
    get(w);
    chk("spare", w, 16'ha3c5);
  endtask

  // every selection code, with the ignored upper bits set
  task automatic t_sel;
    for (int v = 0; v < 16; v++) begin
      cmd(OP_TOUT, 0);
      put(16'hfff0 | 16'(v));
      cmd(OP_CLKSRC, 0);
      put(16'hfffc | 16'(v % 4));
      poll(HSK_WOK);
      chk("out_sel", out_sel, v);
      chk("clk_src", clk_src, v % 4);
    end
  endtask

  task automatic t_conv;
    logic [15:0] w;
    logic [63:0] s;
    for (int n = 0; n < 4; n++) begin
      cmd(OP_ERR, 4'(n));
      get(w);
      chk("err", w, 11'h5a5 ^ 11'(n));
      cmd(OP_LOCK, 4'(n));
      get(w);
      chk("lock", w, n % 2);
      cmd(OP_STAT, 4'(n));
      s = {2'b0, 14'h2a50 + 14'(n), 48'h0123_4567_89ab};
      for (int j = 0; j < STAT_WORDS; j++) begin
        if (j == 2) axi_wr(A_CMD, 32'h0000_c300); // dropped while results wait
        get(w);
        chk("status", w, s[j*16 +: 16]);
      end
    end
  endtask

  task automatic t_eeprom;
    logic [15:0] w;
    // address outside the reserved low region; revision past 0.3, so no 10 ms pause
    cmd(OP_EE_WR, 0);
    put(16'h0130);
    put(16'hbba5);
    cmd(OP_EE_RD, 0);
    put(16'h0130);
    get(w);
    chk("ee strobe", {wr_addr, wr_data}, {9'h130, 8'ha5});
    chk("ee read", w[7:0], 8'ha5);
    cmd(OP_IDENT, 0);
    for (int j = 0; j < ID_WORDS; j++) begin
      get(w);
      chk("ident", w, ID[j]);
    end
  endtask

  task automatic trig(input logic exp);
    logic got = 0;
    @(posedge sys_clk_i) trig_i <= 1'b1;
    @(posedge sys_clk_i) trig_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i) if (t_ins === 1'b1) got = 1;
    chk("insert", got, exp);
  endtask

  task automatic t_test;
    cmd(OP_TEST_EN, 0);
    put(16'hbeef);
    put(16'hff3c);
    poll(HSK_WOK);
    chk("test word", t_word, 32'h203c_beef);
    chk("test_mode", t_mode, 1);
    trig(1'b0);
    axi_wr(A_CTRL, 32'h1);
    trig(1'b1);
    cmd(OP_TEST_DIS, 0);
    poll(HSK_WOK);
    chk("test_mode", t_mode, 0);
    trig(1'b0);
  endtask

  task automatic t_load(input logic [7:0] op, input logic [3:0] exp);
    logic [3:0] v = 0;
    cmd(op, 4'h2);
    repeat (20) @(posedge sys_clk_i) if (|tdc_load && v == 0) v = tdc_load;
    chk("load", v, exp);
  endtask

  task automatic t_scan;
    logic [15:0] w;
    cmd(OP_SCAN_RD, 4'h1);
    for (int k = 0; k < SCAN_WORDS; k++) begin
      get(w);
      chk("scan", w, 16'(4096 + k*7 + 1));
    end
    cmd(OP_SPARE_RD, 0);
    get(w);
    chk("after scan", w, 16'ha3c5);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sel();
    t_conv();
    t_eeprom();
    t_test();
    t_load(OP_LOAD_ONE, 4'b0100);
    t_load(OP_LOAD_ALL, 4'b1111);
    t_scan();
    wrap_up();
  end
endmodule
`default_nettype wire
